// *** acp_pkg.sv ***
// Package for the converter configuration port: register map, field positions,
// reset values and frame layout. Used by acp_config_port and tb_acp_config_port.
package acp_pkg;
    localparam logic [6:0] ACP_ADDR_RESET = 7'h00;
    localparam logic [6:0] ACP_ADDR_FORMAT = 7'h01;
    localparam logic [6:0] ACP_ADDR_OUTMODE = 7'h02;
    localparam logic [6:0] ACP_ADDR_PAT_HI = 7'h03;
    localparam logic [6:0] ACP_ADDR_PAT_LO = 7'h04;
    localparam logic [6:0] ACP_ADDR_CLKRANGE = 7'h05;
    localparam logic [7:0] ACP_RST_FORMAT = 8'h00;
    localparam logic [7:0] ACP_RST_OUTMODE = 8'h00;
    localparam logic [7:0] ACP_RST_PAT_HI = 8'h00;
    localparam logic [7:0] ACP_RST_PAT_LO = 8'h00;
    localparam logic [7:0] ACP_RST_CLKRANGE = 8'h15;
    localparam logic [7:0] ACP_SWRST_CLEAR = 8'h00;
    localparam int ACP_SWRST_BIT = 7;
    localparam int ACP_DCS_OFF_BIT = 7;
    localparam int ACP_SCRAMBLE_BIT = 6;
    localparam int ACP_SIGNED_BIT = 5;
    localparam int ACP_PD_HI_BIT = 4;
    localparam int ACP_PD_MID_BIT = 3;
    localparam int ACP_PD_LO_BIT = 0;
    localparam int ACP_CUR_MSB = 7;
    localparam int ACP_CUR_LSB = 5;
    localparam int ACP_TERM_BIT = 4;
    localparam int ACP_OUTPUT_DISABLE_BIT = 3;
    localparam int ACP_LAYOUT_MSB = 2;
    localparam int ACP_PATEN_BIT = 7;
    localparam int ACP_PAT_HI_MSB = 5;
    localparam int ACP_LPM_BIT = 6;
    localparam int ACP_RANGE_MSB = 1;
    // Writable masks: reserved bits are dropped on write
    localparam logic [7:0] ACP_MASK_FORMAT = 8'hF9;
    localparam logic [7:0] ACP_MASK_PAT_HI = 8'hBF;
    localparam logic [7:0] ACP_MASK_CLKRANGE = 8'h43;
    localparam logic [4:0] ACP_FRAME_BITS = 5'h10;
    localparam logic [4:0] ACP_HDR_BITS = 5'h08;
    localparam logic [2:0] ACP_CUR_3P5 = 3'h0;
    localparam logic [2:0] ACP_CUR_1P75 = 3'h7;
    localparam logic [2:0] ACP_LAYOUT_2L16 = 3'h0;
    localparam logic [2:0] ACP_LAYOUT_1L14 = 3'h5;
    localparam logic [1:0] ACP_RANGE_FORBID = 2'h3;
endpackage

// *** acp_config_port.sv ***
// Configuration port of a dual-channel converter: strap pins drive the core's
// control signals directly, or a 16-bit serial frame writes five mode registers.
// Assumes all pins are asynchronous to mclk_in; serial clock well below mclk_in/4.
// Notes on behaviour
// RQ1 - Select high: control pins are static straps
// RQ2 - Strap chip select picks output layout
// RQ3 - Strap serial clock picks driver current
// RQ4 - Strap serial input high sleeps device
// RQ5 - Strap serial output enables internal termination
// RQ6 - Select low: serial port reaches all registers
// RQ7 - Sample first sixteen rising edges only
// RQ8 - Frame: rw flag, address, data
// RQ9 - Low flag writes, high flag reads back
// RQ10 - Serial output is open-drain pull-down only
// RQ11 - Host sends software reset first
// RQ12 - Reset bit clears registers, self-clears, sleeps
// RQ13 - Format bit 7 turns stabilizer off
// RQ14 - Format bit 6 enables scrambling
// RQ15 - Format bit 5 selects signed coding
// RQ16 - Power-down bits decode nap and sleep
// RQ17 - Output-mode bits 7-5 select driver current
// RQ18 - Termination bit doubles current
// RQ19 - Output-mode bit 3 disables outputs
// RQ20 - Output-mode bits 2-0 select layout
// RQ21 - Pattern registers enable and supply test word
// RQ22 - Clock range band and low-power bit
// RQ23 - Test pattern overrides signed and scramble
// RQ24 - Scramble xors upper bits with lsb
// RQ25 - Read data shifts out msb first
// RQ26 - Reserved bits ignored, reset register reads zero
module acp_config_port
    import acp_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input wire logic mclk_in,                       // System clock, 20 MHz
    input wire logic rst_in,                        // Synchronous reset, active high
    input wire logic ce_in,                         // Clock enable, freezes state when low
    input wire logic interface_select_in,           // High strap mode, low serial mode
    input wire logic cs_n_in,                       // Chip select pin, active low
    input wire logic sclk_in,                       // Serial clock pin
    input wire logic sdi_in,                        // Serial data in pin
    input wire logic sdo_in,                        // Serial out pin level (strap input)
    output logic sdo_out,                           // Open-drain out value, always 0
    output logic sdo_oe_n_out,                      // Low while pulling the pin down
    input wire logic [DATA_W-1:0] conv_data_in,     // Raw offset-binary converter word
    output logic [DATA_W-1:0] out_word_out,         // Formatted output word
    output logic duty_stabilizer_disable_out,       // Stabilizer off
    output logic output_scramble_enable_out,        // Scrambling on
    output logic signed_format_select_out,          // Two's complement coding
    output logic nap_ch1_out,                       // Channel 1 nap
    output logic nap_ch2_out,                       // Channel 2 nap
    output logic sleep_out,                         // Whole device sleep
    output logic [2:0] driver_current_sel_out,      // Driver current code
    output logic internal_term_enable_out,          // Internal termination on
    output logic output_disable_out,                // Digital outputs off
    output logic [2:0] serial_layout_sel_out,       // Output layout code
    output logic pattern_enable_out,                // Test pattern active
    output logic low_power_conv_enable_out,         // Low-power conversion
    output logic [1:0] sample_clock_range_out       // Sample-clock band
);
    typedef enum logic [1:0] {ACP_IDLE, ACP_SHIFT, ACP_DONE} acp_state_e;

    // Two-flop synchronisers; only stage two is read by logic
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic sclk_prev_ff;
    // Chip select resets to its idle high level so no frame opens at reset release
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sync1_ff <= 5'h08;
            sync2_ff <= 5'h08;
            sclk_prev_ff <= 1'b0;
        end else if (ce_in) begin
            sync1_ff <= {interface_select_in, cs_n_in, sclk_in, sdi_in, sdo_in};
            sync2_ff <= sync1_ff;
            sclk_prev_ff <= sync2_ff[2];
        end
    end

    wire sel_strap = sync2_ff[4]; // RQ1
    wire cs_n_s = sync2_ff[3];
    wire sclk_s = sync2_ff[2];
    wire sdi_s = sync2_ff[1];
    wire sdo_s = sync2_ff[0];
    wire sclk_rise = sclk_s & ~sclk_prev_ff;
    wire sclk_fall = ~sclk_s & sclk_prev_ff;
    wire serial_mode = ~sel_strap; // RQ6

    acp_state_e state_ff;
    acp_state_e nxt_state;
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] rd_shift_ff;
    logic sdo_drive_ff;
    logic [7:0] format_ff;
    logic [7:0] outmode_ff;
    logic [7:0] pat_hi_ff;
    logic [7:0] pat_lo_ff;
    logic [7:0] clkrange_ff;
    logic swrst_pulse_ff;
    logic rd_flag_ff;

    // Frame ends on chip select rising; a frame cut short writes nothing
    wire frame_active = serial_mode & ~cs_n_s;
    wire bit_take = frame_active & sclk_rise & (bit_cnt_ff < ACP_FRAME_BITS); // RQ7
    wire [15:0] shift_nxt = {shift_ff[14:0], sdi_s};
    wire frame_done = bit_take & (bit_cnt_ff == ACP_FRAME_BITS - 5'h01);
    wire hdr_done = bit_take & (bit_cnt_ff == ACP_HDR_BITS - 5'h01);
    // The shift register moves on every bit, so the flag is latched once at the header
    wire is_read = rd_flag_ff; // RQ9
    wire hdr_read = shift_nxt[7]; // RQ8
    wire [6:0] hdr_addr = shift_nxt[6:0]; // RQ8
    // Write fields come from the complete 16-bit word at the last bit
    wire [6:0] wr_addr = shift_nxt[14:8];
    wire [7:0] wr_data = shift_nxt[7:0];
    wire commit_wr = frame_done & ~shift_nxt[15]; // RQ9
    wire swrst_hit = commit_wr & (wr_addr == ACP_ADDR_RESET) & wr_data[ACP_SWRST_BIT]; // RQ12

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ACP_IDLE: if (frame_active) nxt_state = ACP_SHIFT;
            ACP_SHIFT: begin
                if (!frame_active) nxt_state = ACP_IDLE;
                else if (frame_done) nxt_state = ACP_DONE;
            end
            ACP_DONE: if (!frame_active) nxt_state = ACP_IDLE;
        endcase
    end

    // Read-back mux; reset register is write-only and reads as zero
    logic [7:0] rd_val;
    always_comb begin
        unique case (hdr_addr)
            ACP_ADDR_FORMAT: rd_val = format_ff;
            ACP_ADDR_OUTMODE: rd_val = outmode_ff;
            ACP_ADDR_PAT_HI: rd_val = pat_hi_ff;
            ACP_ADDR_PAT_LO: rd_val = pat_lo_ff;
            ACP_ADDR_CLKRANGE: rd_val = clkrange_ff;
            default: rd_val = ACP_SWRST_CLEAR; // RQ26
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_ff <= ACP_IDLE;
            bit_cnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            if (!frame_active) begin
                bit_cnt_ff <= 5'h00;
            end else if (bit_take) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                shift_ff <= shift_nxt;
            end
        end
    end

    // Read flag held from the header to the end of the frame
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_flag_ff <= 1'b0;
        end else if (ce_in) begin
            if (!frame_active) begin
                rd_flag_ff <= 1'b0;
            end else if (hdr_done) begin
                rd_flag_ff <= hdr_read; // RQ9
            end
        end
    end

    // Read data: first bit on the falling edge after the header, msb first
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_shift_ff <= 8'h00;
            sdo_drive_ff <= 1'b0;
        end else if (ce_in) begin
            if (!frame_active) begin
                sdo_drive_ff <= 1'b0;
            end else if (hdr_done) begin
                rd_shift_ff <= hdr_read ? rd_val : 8'h00; // RQ25
            end else if (sclk_fall && bit_cnt_ff >= ACP_HDR_BITS
                         && bit_cnt_ff < ACP_FRAME_BITS && is_read) begin
                sdo_drive_ff <= ~rd_shift_ff[7]; // RQ25
                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            end else if (sclk_fall && bit_cnt_ff == ACP_FRAME_BITS) begin
                sdo_drive_ff <= 1'b0;
            end
        end
    end

    // Pin only ever pulled low; a one reads as the host's pull-up
    assign sdo_out = 1'b0; // RQ10
    assign sdo_oe_n_out = ~(sdo_drive_ff & serial_mode); // RQ10

    // Register writes; reserved bits masked away
    always_ff @(posedge mclk_in) begin
        if (rst_in || (ce_in && swrst_hit)) begin // RQ12
            format_ff <= ACP_RST_FORMAT;
            outmode_ff <= ACP_RST_OUTMODE;
            pat_hi_ff <= ACP_RST_PAT_HI;
            pat_lo_ff <= ACP_RST_PAT_LO;
            clkrange_ff <= rst_in ? ACP_RST_CLKRANGE : ACP_SWRST_CLEAR;
        end else if (ce_in && commit_wr) begin
            unique case (wr_addr)
                ACP_ADDR_FORMAT: format_ff <= wr_data & ACP_MASK_FORMAT; // RQ26
                ACP_ADDR_OUTMODE: outmode_ff <= wr_data;
                ACP_ADDR_PAT_HI: pat_hi_ff <= wr_data & ACP_MASK_PAT_HI; // RQ26
                ACP_ADDR_PAT_LO: pat_lo_ff <= wr_data;
                ACP_ADDR_CLKRANGE: clkrange_ff <= wr_data & ACP_MASK_CLKRANGE; // RQ26
                default: ;
            endcase
        end
    end

    // Reset bit is never stored: one-cycle sleep pulse when written
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            swrst_pulse_ff <= 1'b0;
        end else if (ce_in) begin
            swrst_pulse_ff <= swrst_hit; // RQ12
        end
    end

    // Mode decode: straps give only a subset, the rest held at defaults
    wire [2:0] pd_bits = {format_ff[ACP_PD_HI_BIT], format_ff[ACP_PD_MID_BIT],
                          format_ff[ACP_PD_LO_BIT]};
    wire ser_sleep = pd_bits[2]; // RQ16
    wire ser_nap1 = ~pd_bits[2] & pd_bits[0]; // RQ16
    wire ser_nap2 = ~pd_bits[2] & pd_bits[1]; // RQ16
    wire [2:0] strap_cur = sync2_ff[2] ? ACP_CUR_1P75 : ACP_CUR_3P5; // RQ3
    wire [2:0] strap_layout = cs_n_s ? ACP_LAYOUT_1L14 : ACP_LAYOUT_2L16; // RQ2
    wire pat_en = serial_mode & pat_hi_ff[ACP_PATEN_BIT]; // RQ21
    wire scr_en = serial_mode & format_ff[ACP_SCRAMBLE_BIT]; // RQ14
    wire sgn_en = serial_mode & format_ff[ACP_SIGNED_BIT]; // RQ15
    wire [DATA_W-1:0] pattern = DATA_W'({pat_hi_ff[ACP_PAT_HI_MSB:0], pat_lo_ff}); // RQ21
    wire [DATA_W-1:0] signed_word = {conv_data_in[DATA_W-1] ^ sgn_en,
                                     conv_data_in[DATA_W-2:0]}; // RQ15
    wire [DATA_W-1:0] scr_word = scr_en ?
        (signed_word ^ {{(DATA_W-1){signed_word[0]}}, 1'b0}) : signed_word; // RQ24
    wire [DATA_W-1:0] nxt_word = pat_en ? pattern : scr_word; // RQ23

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            out_word_out <= '0;
            duty_stabilizer_disable_out <= 1'b0;
            output_scramble_enable_out <= 1'b0;
            signed_format_select_out <= 1'b0;
            nap_ch1_out <= 1'b0;
            nap_ch2_out <= 1'b0;
            sleep_out <= 1'b0;
            driver_current_sel_out <= ACP_CUR_3P5;
            internal_term_enable_out <= 1'b0;
            output_disable_out <= 1'b0;
            serial_layout_sel_out <= ACP_LAYOUT_2L16;
            pattern_enable_out <= 1'b0;
            low_power_conv_enable_out <= 1'b0;
            sample_clock_range_out <= 2'h0;
        end else if (ce_in) begin
            out_word_out <= nxt_word;
            duty_stabilizer_disable_out <= serial_mode & format_ff[ACP_DCS_OFF_BIT]; // RQ13
            output_scramble_enable_out <= scr_en; // RQ14
            signed_format_select_out <= sgn_en; // RQ15
            nap_ch1_out <= serial_mode & ser_nap1; // RQ16
            nap_ch2_out <= serial_mode & ser_nap2; // RQ16
            sleep_out <= sel_strap ? sdi_s : (ser_sleep | swrst_pulse_ff); // RQ4
            driver_current_sel_out <= sel_strap ? strap_cur
                                    : outmode_ff[ACP_CUR_MSB:ACP_CUR_LSB]; // RQ17
            // RQ5
            internal_term_enable_out <= sel_strap ? sdo_s
                                      : outmode_ff[ACP_TERM_BIT]; // RQ18
            output_disable_out <= serial_mode & outmode_ff[ACP_OUTPUT_DISABLE_BIT]; // RQ19
            serial_layout_sel_out <= sel_strap ? strap_layout
                                   : outmode_ff[ACP_LAYOUT_MSB:0]; // RQ20
            pattern_enable_out <= pat_en; // RQ21
            // Strap mode runs the low-power 8-16 MHz band
            low_power_conv_enable_out <= sel_strap | clkrange_ff[ACP_LPM_BIT]; // RQ22
            sample_clock_range_out <= sel_strap ? 2'h1
                                    : clkrange_ff[ACP_RANGE_MSB:0]; // RQ22
        end
    end

    // Strap mode never drives the serial output pin
    a_strap_no_drive: assert property (@(posedge mclk_in) disable iff (rst_in)
        sel_strap |-> sdo_oe_n_out) // RQ1
        else $error("serial output driven in strap mode");
    a_strap_layout: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sel_strap && $stable(sel_strap) |=>
        serial_layout_sel_out == ($past(cs_n_s) ? ACP_LAYOUT_1L14 : ACP_LAYOUT_2L16)) // RQ2
        else $error("strap layout wrong");
    a_bit_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
        bit_cnt_ff <= ACP_FRAME_BITS) // RQ7
        else $error("bit count past frame length");
    a_swrst_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && swrst_hit |=> format_ff == 8'h00 && clkrange_ff == 8'h00
        && swrst_pulse_ff ##1 (!ce_in || sleep_out)) // RQ12
        else $error("software reset did not clear and sleep");
    a_nap_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && serial_mode && format_ff[ACP_PD_HI_BIT] && $stable(format_ff)
        |=> !nap_ch1_out && !nap_ch2_out && sleep_out) // RQ16
        else $error("sleep does not override nap");
    a_pattern_wins: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && pat_en |=> out_word_out == $past(pattern)) // RQ23
        else $error("pattern not forced on output");
    a_scramble_lsb: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in |=> out_word_out[0] == $past(nxt_word[0])
        && (!$past(scr_en) || $past(pat_en)
            || (out_word_out[1] ^ out_word_out[0]) == $past(signed_word[1]))) // RQ24
        else $error("scramble relation broken");
    a_reserved_mask: assert property (@(posedge mclk_in) disable iff (rst_in)
        (format_ff & ~ACP_MASK_FORMAT) == 8'h00 && pat_hi_ff[6] == 1'b0) // RQ26
        else $error("reserved bit stored");
    a_read_window: assert property (@(posedge mclk_in) disable iff (rst_in)
        !sdo_oe_n_out |-> bit_cnt_ff >= ACP_HDR_BITS && is_read && frame_active) // RQ25
        else $error("serial output driven outside read data phase");

    // Strap pins reach their outputs one cycle after the synchronisers
    a_strap_current: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sel_strap |=>
        driver_current_sel_out == ($past(sclk_s) ? ACP_CUR_1P75 : ACP_CUR_3P5)) // RQ3
        else $error("strap driver current wrong");
    a_strap_sleep: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sel_strap |=> sleep_out == $past(sdi_s)) // RQ4
        else $error("strap sleep wrong");
    a_strap_term: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sel_strap |=> internal_term_enable_out == $past(sdo_s)) // RQ5
        else $error("strap termination wrong");
    a_strap_band: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sel_strap |=> low_power_conv_enable_out && sample_clock_range_out == 2'h1) // RQ22
        else $error("strap clock band wrong");

    // Frame handling: writes land, extra edges and unmapped writes change nothing
    a_write_lands: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && commit_wr && wr_addr == ACP_ADDR_OUTMODE |=> outmode_ff == $past(wr_data)) // RQ9
        else $error("output mode write lost");
    a_extra_edges: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && frame_active && sclk_rise && bit_cnt_ff == ACP_FRAME_BITS
        |=> bit_cnt_ff == ACP_FRAME_BITS && $stable(shift_ff)) // RQ7
        else $error("edge past the frame was taken");
    a_unmapped_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && commit_wr && wr_addr > ACP_ADDR_CLKRANGE
        |=> $stable(format_ff) && $stable(outmode_ff) && $stable(pat_lo_ff)) // RQ26
        else $error("unmapped write changed a register");
    a_read_latch: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && hdr_done |=> rd_flag_ff == $past(hdr_read)) // RQ9
        else $error("read flag not latched at header");

    // Output coding and band codes follow the registers
    a_signed_msb: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && sgn_en && !scr_en && !pat_en
        |=> out_word_out[DATA_W-1] == ~$past(conv_data_in[DATA_W-1])) // RQ15
        else $error("signed coding msb wrong");
    a_range_code: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && serial_mode |=> sample_clock_range_out == $past(clkrange_ff[ACP_RANGE_MSB:0])) // RQ22
        else $error("clock band code wrong");

    c_write_frame: cover property (@(posedge mclk_in) disable iff (rst_in) commit_wr);
    c_read_drive: cover property (@(posedge mclk_in) disable iff (rst_in) !sdo_oe_n_out);
    c_soft_reset: cover property (@(posedge mclk_in) disable iff (rst_in) swrst_hit);
    c_read_frame: cover property (@(posedge mclk_in) disable iff (rst_in)
        frame_done && shift_nxt[15]);
    c_strap_sleep: cover property (@(posedge mclk_in) disable iff (rst_in)
        sel_strap && sleep_out);
endmodule

// *** acp_host_model.sv ***
// Serial master model for the converter configuration port: drives chip select,
// serial clock and data, and collects read data from the open-drain output.
// Assumes the bench resolves the output wire with a pull-up and clocks it at 20 MHz.
module acp_host_model (
    input wire logic mclk_in,     // System clock, pins change just after its edge
    input wire logic sdo_wire_in, // Resolved serial output wire
    output logic cs_n_out,        // Chip select, active low
    output logic sclk_out,        // Serial clock, idle low outside frames
    output logic sdi_out          // Serial data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // Half period of four system cycles gives a 400 ns serial clock
    task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge mclk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_out <= (i < 16) ? word[15 - i] : ~sdi_out;
            wait_clk(4);
            if (i >= 8 && i < 16) begin
                rd = {rd[6:0], sdo_wire_in};
            end
            sclk_out <= 1'b1;
            wait_clk(4);
            sclk_out <= 1'b0;
        end
        wait_clk(4);
        cs_n_out <= 1'b1;
        // Released data line shows the inverse so stale values never look valid
        sdi_out <= ~sdi_out;
        wait_clk(4);
    endtask

    task automatic strap(input logic [2:0] pins);
        @(posedge mclk_in);
        {cs_n_out, sclk_out, sdi_out} <= pins;
    endtask
endmodule

// *** tb_acp_config_port.sv ***
// Self-checking bench for the converter configuration port.
// Assumes acp_pkg and acp_host_model are compiled first; ce_in is held high.
module tb_acp_config_port
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst, sel, sdo_strap, cs_n, sclk, sdi, sdo_w, sdo_oe_n, sdo_pin;
    logic [13:0] conv, word;
    logic dcs, scr, sgn, nap1, nap2, sleep_w, term, dis, paten, lp, sleep_q;
    logic [2:0] cur, lay;
    logic [1:0] rng;
    logic [7:0] r, fv, om;
    logic [7:0] masks [1:5] = '{ACP_MASK_FORMAT, 8'hFF, ACP_MASK_PAT_HI, 8'hFF, ACP_MASK_CLKRANGE};
    logic [2:0] lays [0:7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
    int n_fail = 0;
    int checks_done = 0;
    int sleep_rises = 0;
    int n0;

    // Pull-up on the open-drain wire; in strap mode the bench drives the pin
    assign sdo_pin = sel ? sdo_strap : (sdo_oe_n ? 1'b1 : sdo_w);

    acp_config_port dut_u (
        .mclk_in(mclk), .rst_in(rst), .ce_in(1'b1), .interface_select_in(sel),
        .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_in(sdo_pin),
        .sdo_out(sdo_w), .sdo_oe_n_out(sdo_oe_n), .conv_data_in(conv), .out_word_out(word),
        .duty_stabilizer_disable_out(dcs), .output_scramble_enable_out(scr),
        .signed_format_select_out(sgn), .nap_ch1_out(nap1), .nap_ch2_out(nap2),
        .sleep_out(sleep_w), .driver_current_sel_out(cur), .internal_term_enable_out(term),
        .output_disable_out(dis), .serial_layout_sel_out(lay), .pattern_enable_out(paten),
        .low_power_conv_enable_out(lp), .sample_clock_range_out(rng)
    );

    acp_host_model host_u (
        .mclk_in(mclk), .sdo_wire_in(sdo_pin), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi)
    );

    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        sleep_q <= sleep_w;
        if (sleep_w === 1'b1 && sleep_q === 1'b0) begin
            sleep_rises++;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host_u.frame({1'b0, a, d}, 16, x);
    endtask

    task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host_u.frame({1'b1, a, 8'h00}, 16, x);
        check(what, {8'h00, x}, {8'h00, exp});
    endtask

    function automatic logic [13:0] exp_word(input logic [13:0] d, input logic [7:0] f);
        logic [13:0] w;
        w = f[5] ? (d ^ 14'h2000) : d;
        if (f[6]) begin
            w[13:1] = w[13:1] ^ {13{w[0]}};
        end
        return w;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        sel = 1'b0;
        sdo_strap = 1'b0;
        conv = 14'h2A55;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        check("range_after_reset", {lp, rng}, {1'b0, ACP_RST_CLKRANGE[1:0]});
        n0 = sleep_rises;
        wr(ACP_ADDR_RESET, 8'h80);
        check("swreset_sleep", 16'(sleep_rises - n0), 16'h0001);
        rd_chk("range_cleared", ACP_ADDR_CLKRANGE, 8'h00);
        rd_chk("reset_reg_read", ACP_ADDR_RESET, 8'h00);
        for (int i = 1; i <= 5; i++) begin
            wr(7'(i), 8'hFF);
            rd_chk("reg_readback", 7'(i), masks[i]);
        end
        wr(7'h7F, 8'hA5);
        rd_chk("unmapped", 7'h7F, 8'h00);
        wr(ACP_ADDR_PAT_LO, 8'h3C);
        host_u.frame({1'b0, ACP_ADDR_PAT_LO, 8'hC3}, 12, r);
        rd_chk("short_frame", ACP_ADDR_PAT_LO, 8'h3C);
        host_u.frame({1'b0, ACP_ADDR_PAT_LO, 8'h5A}, 19, r);
        rd_chk("extra_edges", ACP_ADDR_PAT_LO, 8'h5A);
        wr(ACP_ADDR_PAT_HI, 8'h12);
        for (int i = 0; i < 64; i++) begin
            fv = {i[5], i[4], i[3], i[2], i[1], 2'b00, i[0]};
            wr(ACP_ADDR_FORMAT, fv);
            check("format_ctrl", {dcs, scr, sgn, sleep_w}, {fv[7:5], fv[4]});
            check("power_down", {nap1, nap2}, {~fv[4] & fv[0], ~fv[4] & fv[3]});
            check("out_word", word, exp_word(conv, fv));
        end
        wr(ACP_ADDR_FORMAT, 8'h60);
        wr(ACP_ADDR_PAT_LO, 8'h34);
        wr(ACP_ADDR_PAT_HI, 8'hD2);
        check("pattern_word", {paten, 1'b0, word}, 16'h9234);
        for (int i = 0; i < 8; i++) begin
            if (i != 3) begin
                om = {3'(i), 1'(i > 4), 1'(i[0]), lays[i]};
                wr(ACP_ADDR_OUTMODE, om);
                check("output_mode", {cur, term, dis, lay}, om);
            end
        end
        for (int i = 0; i < 3; i++) begin
            wr(ACP_ADDR_CLKRANGE, {1'b1, 1'(i[0]), 4'hF, 2'(i)});
            check("clock_range", {lp, rng}, {1'(i[0]), 2'(i)});
        end
        @(posedge mclk);
        sel <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            host_u.strap(s[3:1]);
            sdo_strap <= s[0];
            repeat (6) @(posedge mclk);
            check("strap_layout", lay, s[3] ? ACP_LAYOUT_1L14 : ACP_LAYOUT_2L16);
            check("strap_current", cur, s[2] ? ACP_CUR_1P75 : ACP_CUR_3P5);
            check("strap_sleep_term", {sleep_w, term}, {s[1], s[0]});
            check("strap_fixed", {scr, sgn, paten, lp, rng}, 16'h0005);
        end
        report_and_stop();
    end
endmodule
